/* File: scb_defs.svh */
// Offsets, field positions, reset values and timing counts of the serial card board control.
`ifndef SCB_DEFS_SVH
`define SCB_DEFS_SVH

// ==========================================================
// Register offsets
`define SCB_OFS_ACCESS 3'h0
`define SCB_OFS_SPARE 3'h1
`define SCB_OFS_LAYOUT 3'h2
`define SCB_OFS_RESET 3'h3
`define SCB_OFS_IRQ_EN 3'h4
`define SCB_OFS_MODE 3'h5
`define SCB_OFS_CODE_LO 3'h6
`define SCB_OFS_CODE_HI 3'h7

// ==========================================================
// Field positions
`define SCB_BIT_ACCESS_EN 7
`define SCB_BIT_RAM_SEL 6
`define SCB_BIT_LAYOUT 7
`define SCB_BIT_IRQ_PEND 5
`define SCB_BIT_RST_STAT 4
`define SCB_BIT_IRQ_EN 6
`define SCB_BIT_LOCAL_LOOP 7
`define SCB_BIT_REMOTE_LOOP 6

// ==========================================================
// Reset values, constant read bits and controller window span
`define SCB_RST_ACCESS 8'h00
`define SCB_RST_LAYOUT 1'b0
`define SCB_RST_IRQ_EN 1'b0
`define SCB_RST_MODE 8'h00
`define SCB_FIX_ACCESS 8'h10
`define SCB_FIX_LAYOUT 8'h20
`define SCB_FIX_RESET 8'h08
`define SCB_CTRL_SPAN 18'h00100

// ==========================================================
// Timing
`define SCB_CLK_NS 4
`define SCB_DECAY_NS 1000
`define SCB_DECAY_CYC ((`SCB_DECAY_NS) / (`SCB_CLK_NS))
`define SCB_HOLD_NS 2000
`define SCB_HOLD_CYC (((`SCB_HOLD_NS) + (`SCB_CLK_NS) - 1) / (`SCB_CLK_NS))
`define SCB_RST_STEPS 8

`endif

/* File: scb_pkg.sv */
// Types shared by the serial card board control.
package scb_pkg;
  typedef enum logic [0:0] {SCB_CHARGED, SCB_HOLDING} scb_rst_state_e;
  typedef logic [3:0] scb_mode_t;
endpackage

/* File: scb_reset_gen.sv */
// Board reset generator that asserts after a series of discharge writes.
`timescale 1ns/100ps
`include "scb_defs.svh"

module scb_reset_gen
  import scb_pkg::*;
#(
  parameter int STEPS = `SCB_RST_STEPS,
  parameter int DECAY_CYC = `SCB_DECAY_CYC,
  parameter int HOLD_CYC = `SCB_HOLD_CYC
)
(
  input wire logic clk_in,         // Board clock.
  input wire logic rst_in,         // Synchronous reset, active high.
  input wire logic clk_en_in,      // Freezes all state while low.
  input wire logic step_in,        // One discharge step per pulse.
  output logic active_out,         // On-board reset active.
  output logic ctrl_rst_n_out      // Controller reset, active low.
);

  // ==========================================================
  // Charge level and hold timer
  // The level leaks back down slowly, so isolated writes never reach the threshold.
  scb_rst_state_e state, next_state;
  logic [7:0] level, next_level;
  logic [15:0] timer, next_timer;

  always_comb
  begin
    next_state = state;
    next_level = level;
    next_timer = timer;
    unique case (state)
      SCB_CHARGED:
      begin
        if (step_in)
        begin
          next_timer = 16'h0000;
          if (level >= 8'(STEPS - 1))
          begin
            next_state = SCB_HOLDING;
            next_timer = 16'h0000;
          end
          else
          begin
            next_level = level + 8'h01;
          end
        end
        else if (level != 8'h00)
        begin
          if (timer >= 16'(DECAY_CYC - 1))
          begin
            next_level = level - 8'h01;
            next_timer = 16'h0000;
          end
          else
          begin
            next_timer = timer + 16'h0001;
          end
        end
      end
      SCB_HOLDING:
      begin
        if (timer >= 16'(HOLD_CYC - 1))
        begin
          next_state = SCB_CHARGED;
          next_level = 8'h00;
          next_timer = 16'h0000;
        end
        else
        begin
          next_timer = timer + 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state <= SCB_CHARGED;
      level <= 8'h00;
      timer <= 16'h0000;
      active_out <= 1'b0;
      ctrl_rst_n_out <= 1'b1;
    end
    else if (clk_en_in)
    begin
      state <= next_state;
      level <= next_level;
      timer <= next_timer;
      active_out <= (next_state == SCB_HOLDING);
      ctrl_rst_n_out <= (next_state != SCB_HOLDING);
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_rst_single_write;
    clk_en_in && step_in && (level == 8'h00) |=> !active_out;
  endproperty
  a_rst_single_write: assert property (p_rst_single_write) else $error("single write caused a reset");

  property p_rst_holds;
    $rose(active_out) && clk_en_in |-> active_out[*4];
  endproperty
  a_rst_holds: assert property (p_rst_holds) else $error("reset pulse too short");

  c_rst_fires: cover property ($rose(active_out));
endmodule

/* File: scb_board_ctrl.sv */
// Control and status register bank of the single-channel serial card.
`timescale 1ns/100ps
`include "scb_defs.svh"

// Operation
// - Access enable bit gates host window accesses; cleared at reset.
// - Select bit routes window to RAM when set, first 256 bytes to controller when clear.
// - Four page bits choose one of sixteen 16K pages via window address.
// - Interrupt enable gates the host interrupt; cleared at reset.
// - Pending status reads 0 while the controller interrupt is pending.
// - Reset status reads 0 while the on-board reset is active.
// - Line mode field clears at reset; code zero tri-states all lines.
// - Mode codes 2,4,5,A,B,D,E,F select the listed line interfaces.
// - Line termination only in 530, 530A, terminated 485 and V.35.
// - Security code is a fixed read-only 16-bit value over two bytes.
// - Layout bit picks 256K linear block or sixteen 16K pages; clears.
// - Each write to offset 3 outside the reset hold steps toward controller reset.
// - Controller port 5 selects line timing source, 0 own, 1 received.
// - Controller window offset bit 6 drives data/control, bit 7 serial/DMA.
// - Registers occupy eight consecutive byte locations.
// - With controller access off, first 256 window bytes are RAM.
module scb_board_ctrl
  import scb_pkg::*;
#(
  parameter logic [15:0] SECURITY_CODE = 16'h5a3c, // Arbitrary value.
  parameter int RST_STEPS = `SCB_RST_STEPS,
  parameter int RST_DECAY_CYC = `SCB_DECAY_CYC,
  parameter int RST_HOLD_CYC = `SCB_HOLD_CYC
)
(
  input wire logic REF_CLK_IN,              // Board clock, 250 MHz.
  input wire logic SYS_RST_IN,              // Synchronous reset, active high.
  input wire logic CLK_EN_IN,               // Freezes all state while low.
  input wire logic [2:0] IO_ADDR_IN,        // I/O byte offset.
  input wire logic IO_WR_IN,                // I/O write strobe.
  input wire logic IO_RD_IN,                // I/O read strobe.
  input wire logic [7:0] IO_WDATA_IN,       // I/O write data.
  output logic [7:0] IO_RDATA_OUT,          // I/O read data.
  input wire logic HOST_WIN_REQ_IN,         // Host window access request.
  input wire logic [17:0] HOST_WIN_ADDR_IN, // Host window offset.
  output logic RAM_CS_OUT,                  // On-board RAM select.
  output logic [17:0] RAM_ADDR_OUT,         // On-board RAM address.
  output logic [4:0] WINDOW_PAGE_ADDR_OUT,  // Window address bits 18..14.
  output logic CTRL_CS_OUT,                 // Controller register select.
  output logic CTRL_DC_OUT,                 // Controller data/control select.
  output logic CTRL_SD_OUT,                 // Controller serial/DMA select.
  output logic LINEAR_MODE_OUT,             // Linear window layout active.
  input wire logic CTRL_IRQ_N_IN,           // Controller interrupt, active low.
  output logic HOST_IRQ_OUT,                // Host interrupt request.
  output logic CTRL_RESET_N_OUT,            // Controller reset, active low.
  output logic [3:0] LINE_MODE_OUT,         // Transceiver mode code.
  output logic LINE_DRV_EN_OUT,             // Line drivers enabled.
  output logic LINE_TERM_EN_OUT,            // Line termination enabled.
  output logic LOCAL_LOOP_OUT,              // Local loopback request.
  output logic REMOTE_LOOP_OUT,             // Remote loopback request.
  input wire logic CTRL_PORT5_IN,           // Controller port 5.
  input wire logic CTRL_PORT6_IN,           // Controller port 6.
  input wire logic CTRL_PORT7_IN,           // Controller port 7.
  input wire logic LINE_RI_IN,              // Line ring indicator.
  input wire logic LINE_DSR_IN,             // Line data set ready.
  output logic TX_TIMING_SEL_OUT,           // 1 selects received transmit clock.
  output logic LINE_RTS_OUT,                // Line request to send.
  output logic LINE_DTR_OUT,                // Line terminal ready.
  output logic TX_REQUEST_INPUT_OUT,        // Controller transmit request input.
  output logic RX_REQUEST_INPUT_OUT         // Controller receive request input.
);

  // ==========================================================
  // Pin synchronisers
  // A change counts once stages two and three agree, filtering a one-cycle glitch for one more cycle of delay.
  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_raw, pin_s1, pin_s2, pin_s3, pin_ok;

  assign pin_raw = {CTRL_IRQ_N_IN, LINE_DSR_IN, LINE_RI_IN, CTRL_PORT7_IN, CTRL_PORT6_IN, CTRL_PORT5_IN};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      always_ff @(posedge REF_CLK_IN)
      begin
        if (SYS_RST_IN)
        begin
          pin_s1[gi] <= 1'b1;
          pin_s2[gi] <= 1'b1;
          pin_s3[gi] <= 1'b1;
          pin_ok[gi] <= 1'b1;
        end
        else if (CLK_EN_IN)
        begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi])
            pin_ok[gi] <= pin_s3[gi];
        end
      end
    end
  endgenerate

  logic port5_ok, port6_ok, port7_ok, ri_ok, dsr_ok, irq_n_ok;
  assign {irq_n_ok, dsr_ok, ri_ok, port7_ok, port6_ok, port5_ok} = pin_ok;

  // ==========================================================
  // Register file
  logic access_en, next_access_en;
  logic ram_sel, next_ram_sel;
  logic [3:0] page, next_page;
  logic linear, next_linear;
  logic irq_en, next_irq_en;
  logic local_loop, next_local_loop;
  logic remote_loop, next_remote_loop;
  scb_mode_t mode, next_mode;
  logic [7:0] next_rdata;
  logic reset_step;
  logic board_rst_active;

  always_comb
  begin
    next_access_en = access_en;
    next_ram_sel = ram_sel;
    next_page = page;
    next_linear = linear;
    next_irq_en = irq_en;
    next_local_loop = local_loop;
    next_remote_loop = remote_loop;
    next_mode = mode;
    next_rdata = IO_RDATA_OUT;
    reset_step = 1'b0;
    if (IO_WR_IN)
    begin
      unique case (IO_ADDR_IN)
        `SCB_OFS_ACCESS:
        begin
          next_access_en = IO_WDATA_IN[`SCB_BIT_ACCESS_EN];
          next_ram_sel = IO_WDATA_IN[`SCB_BIT_RAM_SEL];
          next_page = IO_WDATA_IN[3:0];
        end
        `SCB_OFS_LAYOUT: next_linear = IO_WDATA_IN[`SCB_BIT_LAYOUT];
        `SCB_OFS_RESET: reset_step = 1'b1;
        `SCB_OFS_IRQ_EN: next_irq_en = IO_WDATA_IN[`SCB_BIT_IRQ_EN];
        `SCB_OFS_MODE:
        begin
          next_local_loop = IO_WDATA_IN[`SCB_BIT_LOCAL_LOOP];
          next_remote_loop = IO_WDATA_IN[`SCB_BIT_REMOTE_LOOP];
          next_mode = IO_WDATA_IN[3:0];
        end
        default: ;
      endcase
    end
    if (IO_RD_IN)
    begin
      unique case (IO_ADDR_IN)
        `SCB_OFS_ACCESS: next_rdata = `SCB_FIX_ACCESS | {access_en, ram_sel, 2'b00, page};
        `SCB_OFS_SPARE: next_rdata = 8'h00;
        `SCB_OFS_LAYOUT: next_rdata = `SCB_FIX_LAYOUT | {linear, 7'h00};
        `SCB_OFS_RESET: next_rdata = `SCB_FIX_RESET | {2'b00, irq_n_ok, !board_rst_active, 4'h0};
        `SCB_OFS_IRQ_EN: next_rdata = {1'b0, irq_en, 6'h00};
        `SCB_OFS_MODE: next_rdata = {local_loop, remote_loop, 2'b00, mode};
        `SCB_OFS_CODE_LO: next_rdata = SECURITY_CODE[7:0];
        `SCB_OFS_CODE_HI: next_rdata = SECURITY_CODE[15:8];
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      access_en <= 1'((`SCB_RST_ACCESS) >> `SCB_BIT_ACCESS_EN);
      ram_sel <= 1'b0;
      page <= 4'h0;
      linear <= `SCB_RST_LAYOUT;
      irq_en <= `SCB_RST_IRQ_EN;
      local_loop <= 1'b0;
      remote_loop <= 1'b0;
      mode <= 4'(`SCB_RST_MODE);
      IO_RDATA_OUT <= 8'h00;
    end
    else if (CLK_EN_IN)
    begin
      access_en <= next_access_en;
      ram_sel <= next_ram_sel;
      page <= next_page;
      linear <= next_linear;
      irq_en <= next_irq_en;
      local_loop <= next_local_loop;
      remote_loop <= next_remote_loop;
      mode <= next_mode;
      IO_RDATA_OUT <= next_rdata;
    end
  end

  // ==========================================================
  // Board reset generator
  scb_reset_gen #(
    .STEPS(RST_STEPS),
    .DECAY_CYC(RST_DECAY_CYC),
    .HOLD_CYC(RST_HOLD_CYC)
  ) u_reset_gen (
    .clk_in(REF_CLK_IN),
    .rst_in(SYS_RST_IN),
    .clk_en_in(CLK_EN_IN),
    .step_in(reset_step),
    .active_out(board_rst_active),
    .ctrl_rst_n_out(CTRL_RESET_N_OUT)
  );

  // ==========================================================
  // Line mode decode
  function automatic logic mode_valid(input scb_mode_t m);
    mode_valid = (m == 4'h2) || (m == 4'h4) || (m == 4'h5) || (m >= 4'ha && m != 4'hc);
  endfunction
  function automatic logic mode_term(input scb_mode_t m);
    mode_term = (m == 4'h4) || (m == 4'hd) || (m == 4'he) || (m == 4'hf);
  endfunction

  // ==========================================================
  // Window routing and pin outputs
  // Outputs are registered so each port comes from a flip-flop; window selects trail the request by one cycle.
  logic in_ctrl_span;
  logic [3:0] eff_page;
  logic next_ram_cs, next_ctrl_cs, next_irq;

  always_comb
  begin
    in_ctrl_span = (HOST_WIN_ADDR_IN < `SCB_CTRL_SPAN);
    eff_page = linear ? HOST_WIN_ADDR_IN[17:14] : page;
    next_ram_cs = HOST_WIN_REQ_IN && access_en && (ram_sel || !in_ctrl_span);
    next_ctrl_cs = HOST_WIN_REQ_IN && access_en && !ram_sel && in_ctrl_span;
    next_irq = irq_en && !irq_n_ok;
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      RAM_CS_OUT <= 1'b0;
      RAM_ADDR_OUT <= 18'h00000;
      WINDOW_PAGE_ADDR_OUT <= 5'h00;
      CTRL_CS_OUT <= 1'b0;
      CTRL_DC_OUT <= 1'b0;
      CTRL_SD_OUT <= 1'b0;
      LINEAR_MODE_OUT <= 1'b0;
      HOST_IRQ_OUT <= 1'b0;
      LINE_MODE_OUT <= 4'h0;
      LINE_DRV_EN_OUT <= 1'b0;
      LINE_TERM_EN_OUT <= 1'b0;
      LOCAL_LOOP_OUT <= 1'b0;
      REMOTE_LOOP_OUT <= 1'b0;
      TX_TIMING_SEL_OUT <= 1'b0;
      LINE_RTS_OUT <= 1'b0;
      LINE_DTR_OUT <= 1'b0;
      TX_REQUEST_INPUT_OUT <= 1'b0;
      RX_REQUEST_INPUT_OUT <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      RAM_CS_OUT <= next_ram_cs;
      RAM_ADDR_OUT <= {eff_page, HOST_WIN_ADDR_IN[13:0]};
      WINDOW_PAGE_ADDR_OUT <= {1'b0, eff_page};
      CTRL_CS_OUT <= next_ctrl_cs;
      CTRL_DC_OUT <= HOST_WIN_ADDR_IN[6];
      CTRL_SD_OUT <= HOST_WIN_ADDR_IN[7];
      LINEAR_MODE_OUT <= linear;
      HOST_IRQ_OUT <= next_irq;
      LINE_MODE_OUT <= mode_valid(mode) ? mode : 4'h0;
      LINE_DRV_EN_OUT <= mode_valid(mode);
      LINE_TERM_EN_OUT <= mode_term(mode);
      LOCAL_LOOP_OUT <= local_loop;
      REMOTE_LOOP_OUT <= remote_loop;
      TX_TIMING_SEL_OUT <= port5_ok;
      LINE_RTS_OUT <= port7_ok;
      LINE_DTR_OUT <= port6_ok;
      TX_REQUEST_INPUT_OUT <= ri_ok;
      RX_REQUEST_INPUT_OUT <= dsr_ok;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  property p_access_block;
    CLK_EN_IN && !access_en |=> !RAM_CS_OUT && !CTRL_CS_OUT;
  endproperty
  a_access_block: assert property (p_access_block) else $error("window access while disabled");
  property p_ctrl_route;
    CLK_EN_IN && HOST_WIN_REQ_IN && access_en && !ram_sel && HOST_WIN_ADDR_IN[17:8] == 10'h000
      |=> CTRL_CS_OUT && !RAM_CS_OUT && CTRL_DC_OUT == $past(HOST_WIN_ADDR_IN[6])
          && CTRL_SD_OUT == $past(HOST_WIN_ADDR_IN[7]);
  endproperty
  a_ctrl_route: assert property (p_ctrl_route) else $error("controller access misrouted");
  property p_ram_low;
    CLK_EN_IN && HOST_WIN_REQ_IN && access_en && ram_sel |=> RAM_CS_OUT && !CTRL_CS_OUT;
  endproperty
  a_ram_low: assert property (p_ram_low) else $error("RAM access misrouted");
  property p_page;
    CLK_EN_IN && !linear |=> RAM_ADDR_OUT[17:14] == $past(page) && WINDOW_PAGE_ADDR_OUT == {1'b0, $past(page)};
  endproperty
  a_page: assert property (p_page) else $error("page address wrong");
  property p_irq_gate;
    CLK_EN_IN |=> HOST_IRQ_OUT == ($past(irq_en) && !$past(irq_n_ok));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("host interrupt gating wrong");
  property p_status_read;
    CLK_EN_IN && IO_RD_IN && IO_ADDR_IN == `SCB_OFS_RESET
      |=> IO_RDATA_OUT[`SCB_BIT_IRQ_PEND] == $past(irq_n_ok)
          && IO_RDATA_OUT[`SCB_BIT_RST_STAT] == !$past(board_rst_active);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");
  property p_mode_hiz;
    CLK_EN_IN && !mode_valid(mode) |=> !LINE_DRV_EN_OUT && LINE_MODE_OUT == 4'h0;
  endproperty
  a_mode_hiz: assert property (p_mode_hiz) else $error("drivers on in idle mode");
  property p_term;
    CLK_EN_IN |=> LINE_TERM_EN_OUT == mode_term($past(mode));
  endproperty
  a_term: assert property (p_term) else $error("termination wrong");
  property p_code_read;
    CLK_EN_IN && IO_RD_IN && IO_ADDR_IN == `SCB_OFS_CODE_HI |=> IO_RDATA_OUT == SECURITY_CODE[15:8];
  endproperty
  a_code_read: assert property (p_code_read) else $error("security code wrong");
  property p_loop_back;
    CLK_EN_IN && IO_WR_IN && IO_ADDR_IN == `SCB_OFS_MODE && CLK_EN_IN ##1 CLK_EN_IN
      |=> LOCAL_LOOP_OUT == $past(IO_WDATA_IN[7], 2) && REMOTE_LOOP_OUT == $past(IO_WDATA_IN[6], 2);
  endproperty
  a_loop_back: assert property (p_loop_back) else $error("loopback output wrong");

  c_ctrl_access: cover property (CTRL_CS_OUT && CTRL_SD_OUT);
  c_ram_access: cover property (RAM_CS_OUT && linear);
  c_term_mode: cover property (LINE_TERM_EN_OUT && LINE_DRV_EN_OUT);
  c_irq: cover property (HOST_IRQ_OUT);
endmodule

/* File: scb_ctrl_model.sv */
// Behavioural model of the serial controller chip facing the board logic.
`timescale 1ns/100ps
module scb_ctrl_model
(
  input wire logic clk_in,        // Board clock.
  input wire logic reset_n_in,    // Controller reset, active low.
  input wire logic irq_set_in,    // Asks for an interrupt.
  input wire logic [4:0] pins_in, // Wanted port 5, 6, 7, RI and DSR levels.
  output logic irq_n_out,         // Interrupt, active low.
  output logic [4:0] pins_out     // Pin levels seen by the board.
);
  initial
  begin
    irq_n_out = 1'b1;
    pins_out = 5'h1f;
  end

  // A controller held in reset drops any pending interrupt, as the real chip does.
  always @(negedge clk_in)
  begin
    irq_n_out <= !(reset_n_in && irq_set_in);
    pins_out <= pins_in;
  end
endmodule

/* File: tb_top.sv */
// Self-checking testbench of the serial card board control.
`timescale 1ns/100ps
module tb_top;
  localparam logic [15:0] SEC = 16'hc3a5; // Arbitrary value.
  localparam int STEPS = 3;
  localparam int DECAY = 20;
  localparam int HOLD = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic req = 1'b0;
  logic irq_set = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wd = 8'h00;
  logic [17:0] wa = 18'h00000;
  logic [4:0] pins = 5'h1f;
  logic [7:0] rdat, d;
  logic [17:0] radr, sadr;
  logic [4:0] wpa, spg, pm;
  logic [3:0] lmode, snap;
  logic rcs, cs, dc, sd, lay, hirq, rstn, drv, term, lloop, rloop, tsel, rts, dtr, txr, rxr, irq_n;
  logic [7:0] rst_map [8] = '{8'h10, 8'h00, 8'h20, 8'h38, 8'h00, 8'h00, 8'ha5, 8'hc3};
  int bad_count = 0;
  int check_count = 0;
  int n;

  always #2 clk = ~clk;

  scb_board_ctrl #(.SECURITY_CODE(SEC), .RST_STEPS(STEPS), .RST_DECAY_CYC(DECAY), .RST_HOLD_CYC(HOLD)) dut_u (
    .REF_CLK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(en), .IO_ADDR_IN(addr), .IO_WR_IN(wr), .IO_RD_IN(rd),
    .IO_WDATA_IN(wd), .IO_RDATA_OUT(rdat), .HOST_WIN_REQ_IN(req), .HOST_WIN_ADDR_IN(wa), .RAM_CS_OUT(rcs),
    .RAM_ADDR_OUT(radr), .WINDOW_PAGE_ADDR_OUT(wpa), .CTRL_CS_OUT(cs), .CTRL_DC_OUT(dc), .CTRL_SD_OUT(sd),
    .LINEAR_MODE_OUT(lay), .CTRL_IRQ_N_IN(irq_n), .HOST_IRQ_OUT(hirq), .CTRL_RESET_N_OUT(rstn),
    .LINE_MODE_OUT(lmode), .LINE_DRV_EN_OUT(drv), .LINE_TERM_EN_OUT(term), .LOCAL_LOOP_OUT(lloop),
    .REMOTE_LOOP_OUT(rloop), .CTRL_PORT5_IN(pm[0]), .CTRL_PORT6_IN(pm[1]), .CTRL_PORT7_IN(pm[2]),
    .LINE_RI_IN(pm[3]), .LINE_DSR_IN(pm[4]), .TX_TIMING_SEL_OUT(tsel), .LINE_RTS_OUT(rts), .LINE_DTR_OUT(dtr),
    .TX_REQUEST_INPUT_OUT(txr), .RX_REQUEST_INPUT_OUT(rxr));

  scb_ctrl_model model_u (.clk_in(clk), .reset_n_in(rstn), .irq_set_in(irq_set), .pins_in(pins),
    .irq_n_out(irq_n), .pins_out(pm));

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Strobes are lowered one cycle before the next call may raise them again.
  task automatic wrr(input logic [2:0] a, input logic [7:0] v);
    addr = a;
    wd = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rdr(input logic [2:0] a, output logic [7:0] v);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    v = rdat;
    @(negedge clk);
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    rdr(a, v);
    chk("io_read", {10'h000, e}, {10'h000, v});
  endtask

  // A window select stands one cycle only, so it is captured just after the request drops, before the next rising edge.
  task automatic win(input logic [17:0] a);
    wa = a;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    snap = {rcs, cs, dc, sd};
    sadr = radr;
    spg = wpa;
    @(negedge clk);
  endtask

  initial
  begin
    #200000;
    bad_count++;
    test_done();
  end

  // ==========================================================
  // Test sequence
  initial
  begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++)
      rdc(i[2:0], rst_map[i]);
    wrr(3'h0, 8'hc5);
    rdc(3'h0, 8'hd5);
    wrr(3'h1, 8'hff);
    rdc(3'h1, 8'h00);
    wrr(3'h6, 8'h00);
    rdc(3'h6, 8'ha5);
    win(18'h00123);
    chk("ram_select", 18'h2, {16'h0, snap[3:2]});
    chk("ram_addr", 18'h14123, sadr);
    chk("page_addr", 18'h5, {13'h0, spg});
    wrr(3'h0, 8'h80);
    win(18'h00080);
    chk("ctrl_select", 18'h5, {14'h0, snap});
    win(18'h00040);
    chk("ctrl_select", 18'h6, {14'h0, snap});
    win(18'h00200);
    chk("ram_select", 18'h2, {16'h0, snap[3:2]});
    wrr(3'h0, 8'h45);
    win(18'h00123);
    chk("no_select", 18'h0, {16'h0, snap[3:2]});
    wrr(3'h2, 8'hff);
    rdc(3'h2, 8'ha0);
    wrr(3'h0, 8'hc0);
    win(18'h2c123);
    chk("linear_addr", 18'h2c123, sadr);
    chk("linear_mode", 18'h1, {17'h0, lay});
    wrr(3'h5, 8'hc2);
    rdc(3'h5, 8'hc2);
    chk("loops", 18'h3, {16'h0, lloop, rloop});
    for (int c = 0; c < 16; c++)
    begin
      wrr(3'h5, {4'h0, c[3:0]});
      n = (c inside {2, 4, 5, 10, 11, 13, 14, 15}) ? 1 : 0;
      chk("line_mode", n ? c[17:0] : 18'h0, {14'h0, lmode});
      chk("line_drive", n[17:0], {17'h0, drv});
      chk("line_term", (c inside {4, 13, 14, 15}) ? 18'h1 : 18'h0, {17'h0, term});
    end
    en = 1'b0;
    wrr(3'h4, 8'h40);
    en = 1'b1;
    rdc(3'h4, 8'h00);
    wrr(3'h4, 8'h40);
    irq_set = 1'b1;
    repeat (8) @(negedge clk);
    rdc(3'h3, 8'h18);
    chk("host_irq", 18'h1, {17'h0, hirq});
    wrr(3'h4, 8'h00);
    chk("host_irq", 18'h0, {17'h0, hirq});
    irq_set = 1'b0;
    foreach (rst_map[i])
    begin
      pins = i[0] ? 5'h0a : 5'h15;
      repeat (8) @(negedge clk);
      chk("port_pins", {13'h0, pins}, {13'h0, rxr, txr, rts, dtr, tsel});
    end
    wrr(3'h3, 8'h00);
    wrr(3'h3, 8'hff);
    chk("ctrl_reset_n", 18'h1, {17'h0, rstn});
    repeat (3 * DECAY) @(negedge clk);
    wrr(3'h3, 8'h00);
    wrr(3'h3, 8'h00);
    chk("ctrl_reset_n", 18'h1, {17'h0, rstn});
    repeat (3 * DECAY) @(negedge clk);
    n = 0;
    d = 8'h10;
    while (d[4] !== 1'b0 && n < 10)
    begin
      wrr(3'h3, 8'h5a);
      rdr(3'h3, d);
      n++;
    end
    chk("reset_writes", STEPS[17:0], n[17:0]);
    chk("reset_status", 18'h28, {10'h0, d});
    chk("ctrl_reset_n", 18'h0, {17'h0, rstn});
    n = 0;
    while (d[4] !== 1'b1 && n < 4 * HOLD)
    begin
      rdr(3'h3, d);
      n++;
    end
    chk("reset_status", 18'h38, {10'h0, d});
    chk("ctrl_reset_n", 18'h1, {17'h0, rstn});
    test_done();
  end
endmodule
